//--- motor_param_pkg.sv
// Constants and carrier types of the motor driver parameter store.
// Assumes a single 50 MHz clock and a same-clock command master.
package motor_param_pkg;
  localparam int NREG = 20;
  typedef logic [4:0] reg_idx_t;
  localparam logic [15:0] WRITE_FLAG = 16'h1000;
  localparam logic [15:0] CODE_MASK  = 16'h0FFF;
  // Clock and supervision timing
  localparam int CLK_HZ = 50000000;
  localparam int TIMEOUT_UNIT_MS = 1;
  localparam int CYCLES_PER_MS_DFLT = CLK_HZ / 1000 * TIMEOUT_UNIT_MS;
  localparam logic [4:0] INCH_SPEED_LOW = 5'h10;
  localparam logic [31:0] INCH_SPEED_MIN = 32'h00000050;
  // Register index order matches the tables below
  localparam reg_idx_t IDX_INCH_SPEED   = 5'h00;
  localparam reg_idx_t IDX_SPEED_DISP   = 5'h01;
  localparam reg_idx_t IDX_EDIT_EN      = 5'h02;
  localparam reg_idx_t IDX_RUN_MODE     = 5'h03;
  localparam reg_idx_t IDX_INCH_TORQUE  = 5'h04;
  localparam reg_idx_t IDX_BRAKE_ALARM  = 5'h05;
  localparam reg_idx_t IDX_BLOCK_RUN    = 5'h06;
  localparam reg_idx_t IDX_THERMAL      = 5'h07;
  localparam reg_idx_t IDX_OVL_EN       = 5'h08;
  localparam reg_idx_t IDX_OVL_LEVEL    = 5'h09;
  localparam reg_idx_t IDX_INIT_DISP    = 5'h0A;
  localparam reg_idx_t IDX_ANALOG_SEL   = 5'h0B;
  localparam reg_idx_t IDX_SPD_GAIN     = 5'h0C;
  localparam reg_idx_t IDX_SPD_OFFSET   = 5'h0D;
  localparam reg_idx_t IDX_TRQ_GAIN     = 5'h0E;
  localparam reg_idx_t IDX_TRQ_OFFSET   = 5'h0F;
  localparam reg_idx_t IDX_SPD_CEILING  = 5'h10;
  localparam reg_idx_t IDX_TRQ_CEILING  = 5'h11;
  localparam reg_idx_t IDX_LINK_TIMEOUT = 5'h12;
  localparam reg_idx_t IDX_ERR_LIMIT    = 5'h13;
  localparam logic [11:0] READ_CODE [NREG] = '{
    12'h143, 12'h1E0, 12'h1E1, 12'h816, 12'h821, 12'h840, 12'h841,
    12'h843, 12'h851, 12'h855, 12'h870, 12'h871, 12'h8D0, 12'h8D1,
    12'h8D2, 12'h8D3, 12'h8D5, 12'h8D7, 12'h900, 12'h901};
  localparam logic [31:0] RESET_VAL [NREG] = '{
    32'h0000012C, 32'h00000000, 32'h00000001, 32'h00000001, 32'h000000C8,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000064,
    32'h00000000, 32'h00000001, 32'h00000320, 32'h00000000, 32'h00000028,
    32'h00000000, 32'h00000FA0, 32'h000000C8, 32'h00000000, 32'h00000003};
  localparam logic [31:0] MIN_VAL [NREG] = '{
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000032,
    32'h00000000, 32'h00000000, 32'h00000000, 32'hFFFFF830, 32'h00000000,
    32'hFFFFFFCE, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000001};
  localparam logic [31:0] MAX_VAL [NREG] = '{
    32'h000003E8, 32'h00000001, 32'h00000001, 32'h00000001, 32'h000000C8,
    32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001, 32'h00000064,
    32'h00000004, 32'h00000002, 32'h00000FA0, 32'h000007D0, 32'h000000C8,
    32'h00000032, 32'h00000FA0, 32'h000000C8, 32'h00002710, 32'h0000000A};
  typedef struct packed {
    logic        valid;
    logic [15:0] code;
    logic [31:0] wdata;
  } cmd_t;
  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] rdata;
  } rsp_t;
  typedef struct packed {
    logic [9:0]  inching_run_speed;
    logic [7:0]  inching_run_torque;
    logic        speed_display_abs;
    logic        setter_edit_en;
    logic        pwm_shutoff_sel;
    logic [2:0]  setter_initial_display;
    logic [11:0] speed_gain;
    logic [7:0]  torque_gain;
  } cfg_t;
endpackage

//--- param_decode.sv
// Command code decoder and range checker for the parameter store.
// Assumes codes with the write flag clear read and with it set write.
`timescale 1ns/100ps
`default_nettype none
module param_decode (
  input  wire logic [15:0]              code,
  input  wire logic [31:0]              wdata,
  output logic                          hit,
  output logic                          is_write,
  output motor_param_pkg::reg_idx_t     idx,
  output logic                          in_range
);
  import motor_param_pkg::*;
  always_comb begin
    hit      = 1'b0;
    idx      = '0;
    is_write = (code & ~CODE_MASK) == WRITE_FLAG;
    for (int i = 0; i < NREG; i++) begin
      if ((code & ~CODE_MASK) <= WRITE_FLAG && code[11:0] == READ_CODE[i]) begin
        hit = 1'b1;
        idx = reg_idx_t'(i);
      end
    end
    in_range = $signed(wdata) >= $signed(MIN_VAL[idx]) &&
               $signed(wdata) <= $signed(MAX_VAL[idx]);
    // Inching speed has a hole between zero and the low limit
    if (idx == IDX_INCH_SPEED && wdata != 32'h0 && wdata < INCH_SPEED_MIN) begin
      in_range = 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- motor_driver_parameter_bank.sv
// Parameter store of a brushless motor driver and the logic it steers.
// Assumes a same-clock command master; alarm pins arrive asynchronously.
`timescale 1ns/100ps
`default_nettype none
module motor_driver_parameter_bank #(
  parameter int CYCLES_PER_MS = motor_param_pkg::CYCLES_PER_MS_DFLT
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire motor_param_pkg::cmd_t  cmd,
  output motor_param_pkg::rsp_t       rsp,
  input  wire logic                   config_exec,
  input  wire logic                   alarm_pin,
  input  wire logic                   alarm_reset_pin,
  input  wire logic                   motor_stopped,
  input  wire logic                   initial_alarm,
  input  wire logic [3:0]             op_data_no,
  input  wire logic [15:0]            digital_speed,
  input  wire logic [7:0]             digital_torque,
  input  wire logic [15:0]            analog_speed_in,
  input  wire logic [7:0]             analog_torque_in,
  input  wire logic [7:0]             load_pct,
  output motor_param_pkg::cfg_t       cfg,
  output logic                        thermal_detect_active,
  output logic [15:0]                 applied_speed,
  output logic [7:0]                  applied_torque,
  output logic                        speed_from_analog,
  output logic                        torque_from_analog,
  output logic                        overload_warning,
  output logic                        primary_alarm_output,
  output logic                        motor_stop,
  output logic                        brake_engage,
  output logic                        run_inhibit,
  output logic                        link_alarm,
  output logic [3:0]                  link_error_count
);
  import motor_param_pkg::*;

  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] hi);
    if ($signed(v) < 0) begin
      clamp = 32'h0;
    end else if ($signed(v) > $signed(hi)) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction

  logic     dec_hit;
  logic     dec_write;
  reg_idx_t dec_idx;
  logic     dec_in_range;

  param_decode u_decode (
    .code     (cmd.code),
    .wdata    (cmd.wdata),
    .hit      (dec_hit),
    .is_write (dec_write),
    .idx      (dec_idx),
    .in_range (dec_in_range)
  );

  // Parameter store
  logic [31:0] regs_q [NREG];
  logic [31:0] regs_d [NREG];
  rsp_t        rsp_q, rsp_d;
  logic        wr_ok;
  logic        link_err;

  always_comb begin
    regs_d   = regs_q;
    rsp_d    = '0;
    wr_ok    = cmd.valid && dec_hit && dec_write && dec_in_range;
    link_err = cmd.valid && !(dec_hit && (!dec_write || dec_in_range));
    if (wr_ok) begin
      regs_d[dec_idx] = cmd.wdata;
    end
    if (cmd.valid) begin
      rsp_d.valid = 1'b1;
      rsp_d.err   = link_err;
      rsp_d.rdata = (dec_hit && !dec_write) ? regs_q[dec_idx] : 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regs_q <= RESET_VAL;
      rsp_q  <= '0;
    end else begin
      regs_q <= regs_d;
      rsp_q  <= rsp_d;
    end
  end

  assign rsp = rsp_q;

  // Exported immediate settings
  always_comb begin
    cfg.inching_run_speed      = regs_q[IDX_INCH_SPEED][9:0];
    cfg.inching_run_torque     = regs_q[IDX_INCH_TORQUE][7:0];
    cfg.speed_display_abs      = regs_q[IDX_SPEED_DISP][0];
    cfg.setter_edit_en         = regs_q[IDX_EDIT_EN][0];
    cfg.pwm_shutoff_sel        = regs_q[IDX_RUN_MODE][0];
    cfg.setter_initial_display = regs_q[IDX_INIT_DISP][2:0];
    cfg.speed_gain             = regs_q[IDX_SPD_GAIN][11:0];
    cfg.torque_gain            = regs_q[IDX_TRQ_GAIN][7:0];
  end

  // Deferred thermal setting, loaded only by configuration
  logic thermal_q, thermal_d;
  always_comb begin
    thermal_d = thermal_q;
    if (config_exec) begin
      thermal_d = regs_q[IDX_THERMAL][0];
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      thermal_q <= RESET_VAL[IDX_THERMAL][0];
    end else begin
      thermal_q <= thermal_d;
    end
  end
  assign thermal_detect_active = thermal_q;

  // Pin synchronisers
  logic alm_s1_q, alm_s2_q, rst_s1_q, rst_s2_q, rst_s3_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      alm_s1_q <= 1'b0;
      alm_s2_q <= 1'b0;
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
      rst_s3_q <= 1'b0;
    end else begin
      alm_s1_q <= alarm_pin;
      alm_s2_q <= alm_s1_q;
      rst_s1_q <= alarm_reset_pin;
      rst_s2_q <= rst_s1_q;
      rst_s3_q <= rst_s2_q;
    end
  end
  // Alarm reset acts on the falling edge of the reset input
  logic alarm_clear;
  assign alarm_clear = rst_s3_q && !rst_s2_q;

  // Link supervision: timeout and error count
  logic [15:0] tick_q, tick_d;
  logic [13:0] idle_ms_q, idle_ms_d;
  logic [3:0]  err_cnt_q, err_cnt_d;
  logic        link_alarm_q, link_alarm_d;
  logic        timeout_hit, err_limit_hit;

  always_comb begin
    tick_d        = tick_q;
    idle_ms_d     = idle_ms_q;
    err_cnt_d     = err_cnt_q;
    link_alarm_d  = link_alarm_q;
    timeout_hit   = 1'b0;
    err_limit_hit = 1'b0;
    if (cmd.valid || regs_q[IDX_LINK_TIMEOUT] == 32'h0) begin
      tick_d    = '0;
      idle_ms_d = '0;
    end else if (tick_q == 16'(CYCLES_PER_MS - 1)) begin
      tick_d    = '0;
      idle_ms_d = idle_ms_q + 14'h1;
    end else begin
      tick_d = tick_q + 16'h1;
    end
    // Zero timeout turns timeout supervision off; the error count still runs
    if (regs_q[IDX_LINK_TIMEOUT] != 32'h0 &&
        {18'h0, idle_ms_q} >= regs_q[IDX_LINK_TIMEOUT]) begin
      timeout_hit = 1'b1;
      idle_ms_d   = '0;
    end
    if (link_err) begin
      if ({28'h0, err_cnt_q} + 32'h1 >= regs_q[IDX_ERR_LIMIT]) begin
        err_limit_hit = 1'b1;
        err_cnt_d     = '0;
      end else begin
        err_cnt_d = err_cnt_q + 4'h1;
      end
    end
    if (alarm_clear) begin
      link_alarm_d = 1'b0;
    end
    // Set wins over a simultaneous clear
    if (timeout_hit || err_limit_hit) begin
      link_alarm_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_q       <= '0;
      idle_ms_q    <= '0;
      err_cnt_q    <= '0;
      link_alarm_q <= 1'b0;
    end else begin
      tick_q       <= tick_d;
      idle_ms_q    <= idle_ms_d;
      err_cnt_q    <= err_cnt_d;
      link_alarm_q <= link_alarm_d;
    end
  end
  assign link_alarm       = link_alarm_q;
  assign link_error_count = err_cnt_q;

  // Alarm consequences and operating data routing
  logic        any_alarm;
  logic        stop_q, stop_d, brake_q, brake_d, inhibit_q, inhibit_d;
  logic        ovl_q, ovl_d, spd_an_q, spd_an_d, trq_an_q, trq_an_d;
  logic [15:0] speed_q, speed_d;
  logic [7:0]  torque_q, torque_d;
  logic [31:0] an_spd, an_trq;

  assign any_alarm = alm_s2_q || link_alarm_q;

  always_comb begin
    stop_d    = any_alarm;
    brake_d   = any_alarm && (regs_q[IDX_BRAKE_ALARM][0] || motor_stopped);
    inhibit_d = regs_q[IDX_BLOCK_RUN][0] && initial_alarm;
    ovl_d     = regs_q[IDX_OVL_EN][0] &&
                {24'h0, load_pct} >= regs_q[IDX_OVL_LEVEL];
    spd_an_d  = regs_q[IDX_ANALOG_SEL][1:0] == 2'h1 && op_data_no == 4'h0;
    trq_an_d  = regs_q[IDX_ANALOG_SEL][1:0] == 2'h2;
    an_spd    = clamp({16'h0, analog_speed_in} + regs_q[IDX_SPD_OFFSET],
                      regs_q[IDX_SPD_CEILING]);
    an_trq    = clamp({24'h0, analog_torque_in} + regs_q[IDX_TRQ_OFFSET],
                      regs_q[IDX_TRQ_CEILING]);
    speed_d   = spd_an_d ? an_spd[15:0] : digital_speed;
    torque_d  = trq_an_d ? an_trq[7:0] : digital_torque;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stop_q    <= 1'b0;
      brake_q   <= 1'b0;
      inhibit_q <= 1'b0;
      ovl_q     <= 1'b0;
      spd_an_q  <= 1'b0;
      trq_an_q  <= 1'b0;
      speed_q   <= '0;
      torque_q  <= '0;
    end else begin
      stop_q    <= stop_d;
      brake_q   <= brake_d;
      inhibit_q <= inhibit_d;
      ovl_q     <= ovl_d;
      spd_an_q  <= spd_an_d;
      trq_an_q  <= trq_an_d;
      speed_q   <= speed_d;
      torque_q  <= torque_d;
    end
  end

  assign motor_stop           = stop_q;
  assign primary_alarm_output = !stop_q;
  assign brake_engage         = brake_q;
  assign run_inhibit          = inhibit_q;
  assign overload_warning     = ovl_q;
  assign speed_from_analog    = spd_an_q;
  assign torque_from_analog   = trq_an_q;
  assign applied_speed        = speed_q;
  assign applied_torque       = torque_q;

  // Checks
  sequence s_good_write;
    cmd.valid && dec_hit && dec_write && dec_in_range;
  endsequence
  sequence s_bad_write;
    cmd.valid && dec_hit && dec_write && !dec_in_range;
  endsequence

  property p_write_lands;
    @(posedge clk) disable iff (rst)
    s_good_write |=> regs_q[$past(dec_idx)] == $past(cmd.wdata);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write lost");

  property p_refuse;
    @(posedge clk) disable iff (rst)
    s_bad_write |=> regs_q[$past(dec_idx)] == $past(regs_q[dec_idx]) && rsp.err;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad write kept");

  property p_ranged;
    @(posedge clk) disable iff (rst)
    $signed(regs_q[IDX_SPD_OFFSET]) >= -2000 && $signed(regs_q[IDX_SPD_OFFSET]) <= 2000 &&
    regs_q[IDX_SPD_GAIN] <= 32'h00000FA0 && regs_q[IDX_ANALOG_SEL] <= 32'h00000002;
  endproperty
  a_ranged: assert property (p_ranged) else $error("value out of range");

  property p_thermal_deferred;
    @(posedge clk) disable iff (rst)
    !config_exec |=> thermal_q == $past(thermal_q);
  endproperty
  a_thermal_deferred: assert property (p_thermal_deferred)
    else $error("thermal changed early");

  property p_alarm_stop;
    @(posedge clk) disable iff (rst)
    any_alarm |=> motor_stop && !primary_alarm_output;
  endproperty
  a_alarm_stop: assert property (p_alarm_stop) else $error("alarm not acted");

  property p_brake_now;
    @(posedge clk) disable iff (rst)
    any_alarm && regs_q[IDX_BRAKE_ALARM][0] |=> brake_engage;
  endproperty
  a_brake_now: assert property (p_brake_now) else $error("brake late");

  property p_brake_wait;
    @(posedge clk) disable iff (rst)
    !regs_q[IDX_BRAKE_ALARM][0] && !motor_stopped |=> !brake_engage;
  endproperty
  a_brake_wait: assert property (p_brake_wait) else $error("brake early");

  property p_err_alarm;
    @(posedge clk) disable iff (rst)
    link_err && {28'h0, err_cnt_q} + 32'h1 >= regs_q[IDX_ERR_LIMIT] |=> link_alarm;
  endproperty
  a_err_alarm: assert property (p_err_alarm) else $error("no error alarm");

  property p_no_timeout_off;
    @(posedge clk) disable iff (rst)
    regs_q[IDX_LINK_TIMEOUT] == 32'h0 && !link_alarm && !link_err ##1
      regs_q[IDX_LINK_TIMEOUT] == 32'h0 && !link_err |-> !link_alarm;
  endproperty
  a_no_timeout_off: assert property (p_no_timeout_off)
    else $error("monitor while off");

  property p_routing;
    @(posedge clk) disable iff (rst)
    regs_q[IDX_ANALOG_SEL][1:0] == 2'h0 |=> !speed_from_analog && !torque_from_analog;
  endproperty
  a_routing: assert property (p_routing) else $error("analog used at zero");

  property p_ovl;
    @(posedge clk) disable iff (rst)
    !regs_q[IDX_OVL_EN][0] |=> !overload_warning;
  endproperty
  a_ovl: assert property (p_ovl) else $error("warning while off");
endmodule
`default_nettype wire

//--- cmd_master.sv
// Command master model for the parameter bank command port.
// Assumes answers arrive within three cycles of the taking edge.
`timescale 1ns/100ps
`default_nettype none
module cmd_master (
  input  wire logic                  clk,
  input  wire motor_param_pkg::rsp_t rsp,
  output motor_param_pkg::cmd_t      cmd
);
  import motor_param_pkg::*;
  initial cmd = '0;
  // Held one cycle, so it is taken at the next edge
  task automatic xfer(input logic wr, input logic [11:0] c, input logic [31:0] d,
                      output logic err, output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    err = 1'b0;
    rd = 32'h0;
    @(posedge clk);
    cmd <= '{valid: 1'b1, code: {3'h0, wr, c}, wdata: d};
    @(posedge clk);
    // Released lines must not keep the last value
    cmd <= '{valid: 1'b0, code: ~{3'h0, wr, c}, wdata: ~d};
    for (n = 0; n < 4; n++) begin
      #1;
      if (!ok && rsp.valid === 1'b1) begin
        ok = 1'b1;
        err = rsp.err;
        rd = rsp.rdata;
      end
      if (!ok) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench of the motor driver parameter bank.
// Assumes the cmd_master model and a shortened millisecond count.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import motor_param_pkg::*;
  localparam logic [31:0] EXP_RST [20] = '{32'h12C, 32'h0, 32'h1, 32'h1, 32'hC8, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h64, 32'h0, 32'h1, 32'h320, 32'h0, 32'h28, 32'h0, 32'hFA0,
    32'hC8, 32'h0, 32'h3};
  localparam logic [11:0] RC [13] = '{12'h8D0, 12'h8D1, 12'h8D2, 12'h8D3, 12'h8D5,
    12'h8D7, 12'h855, 12'h143, 12'h821, 12'h870, 12'h871, 12'h900, 12'h901};
  localparam logic [31:0] RG [13] = '{32'hFA0, 32'hFFFFF830, 32'hC8, 32'hFFFFFFCE,
    32'h0, 32'hC8, 32'h32, 32'h50, 32'h0, 32'h4, 32'h2, 32'h2710, 32'hA};
  localparam logic [31:0] RB [13] = '{32'hFA1, 32'hFFFFF82F, 32'hC9, 32'hFFFFFFCD,
    32'hFA1, 32'hC9, 32'h31, 32'h4F, 32'hC9, 32'h5, 32'h3, 32'h2711, 32'h0};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        config_exec = 1'b0;
  logic        alarm_pin = 1'b0;
  logic        alarm_reset_pin = 1'b0;
  logic        motor_stopped = 1'b0;
  logic        initial_alarm = 1'b0;
  logic [3:0]  op_data_no = 4'h0;
  logic [15:0] digital_speed = 16'h1F4;
  logic [7:0]  digital_torque = 8'h5A;
  logic [15:0] analog_speed_in = 16'h64;
  logic [7:0]  analog_torque_in = 8'h1E;
  logic [7:0]  load_pct = 8'h0;
  cmd_t        cmd;
  rsp_t        rsp;
  cfg_t        cfg;
  logic        thermal, spd_an, trq_an, ovl, prim, mstop, brake, inhibit, lalarm;
  logic [15:0] app_speed;
  logic [7:0]  app_torque;
  logic [3:0]  err_count;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles = 0;
  always #10 clk = ~clk;
  cmd_master m (.clk(clk), .rsp(rsp), .cmd(cmd));
  motor_driver_parameter_bank #(.CYCLES_PER_MS(10)) dut (
    .clk(clk), .rst(rst), .cmd(cmd), .rsp(rsp), .config_exec(config_exec),
    .alarm_pin(alarm_pin), .alarm_reset_pin(alarm_reset_pin),
    .motor_stopped(motor_stopped), .initial_alarm(initial_alarm),
    .op_data_no(op_data_no), .digital_speed(digital_speed),
    .digital_torque(digital_torque), .analog_speed_in(analog_speed_in),
    .analog_torque_in(analog_torque_in), .load_pct(load_pct), .cfg(cfg),
    .thermal_detect_active(thermal), .applied_speed(app_speed),
    .applied_torque(app_torque), .speed_from_analog(spd_an),
    .torque_from_analog(trq_an), .overload_warning(ovl),
    .primary_alarm_output(prim), .motor_stop(mstop), .brake_engage(brake),
    .run_inhibit(inhibit), .link_alarm(lalarm), .link_error_count(err_count));
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic check_bit(input string what, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic op(input logic wr, input logic [11:0] c, input logic [31:0] d,
                    input logic e, output logic [31:0] rd);
    logic er;
    logic ok;
    m.xfer(wr, c, d, er, rd, ok);
    check_bit("answer", 1'b1, ok);
    check_bit("error", e, er);
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset_values;
    logic [31:0] rd;
    for (int i = 0; i < NREG; i++) begin
      op(1'b0, READ_CODE[i], 32'h0, 1'b0, rd);
      check_word("reset value", EXP_RST[i], rd);
    end
    check_bit("alarm idle", 1'b1, prim);
    $display("done reset_values");
  endtask
  task automatic t_range;
    logic [31:0] rd;
    for (int i = 0; i < 13; i++) begin
      op(1'b1, RC[i], RG[i], 1'b0, rd);
      op(1'b1, RC[i], RB[i], 1'b1, rd);
      op(1'b0, RC[i], 32'h0, 1'b0, rd);
      check_word("kept", RG[i], rd);
    end
    op(1'b1, 12'h143, 32'h0, 1'b0, rd);
    op(1'b0, 12'h8D4, 32'h0, 1'b1, rd);
    $display("done range");
  endtask
  task automatic t_apply;
    logic [31:0] rd;
    check_bit("edit reset", 1'b1, cfg.setter_edit_en);
    check_word("cfg inching", 32'h12CC8,
               {14'h0, cfg.inching_run_speed, cfg.inching_run_torque});
    check_word("cfg gains", 32'h32028, {12'h0, cfg.speed_gain, cfg.torque_gain});
    check_word("cfg display", 32'h0, {29'h0, cfg.setter_initial_display});
    op(1'b1, 12'h1E0, 32'h1, 1'b0, rd);
    check_bit("display abs", 1'b1, cfg.speed_display_abs);
    op(1'b1, 12'h1E1, 32'h0, 1'b0, rd);
    check_bit("edit off", 1'b0, cfg.setter_edit_en);
    op(1'b1, 12'h816, 32'h0, 1'b0, rd);
    check_bit("pwm mode", 1'b0, cfg.pwm_shutoff_sel);
    op(1'b1, 12'h843, 32'h1, 1'b0, rd);
    settle(3);
    check_bit("thermal held", 1'b0, thermal);
    @(posedge clk);
    config_exec <= 1'b1;
    @(posedge clk);
    config_exec <= 1'b0;
    settle(2);
    check_bit("thermal loaded", 1'b1, thermal);
    $display("done apply");
  endtask
  task automatic t_route;
    logic [31:0] rd;
    settle(2);
    check_word("speed sel1 op0", 32'h64, {16'h0, app_speed});
    check_bit("speed analog", 1'b1, spd_an);
    @(posedge clk);
    op_data_no <= 4'h1;
    settle(2);
    check_word("speed sel1 op1", 32'h1F4, {16'h0, app_speed});
    check_word("torque sel1", 32'h5A, {24'h0, app_torque});
    @(posedge clk);
    op_data_no <= 4'h0;
    op(1'b1, 12'h871, 32'h2, 1'b0, rd);
    settle(2);
    check_word("torque sel2", 32'h1E, {24'h0, app_torque});
    check_bit("speed sel2", 1'b0, spd_an);
    op(1'b1, 12'h8D3, 32'hFFFFFFCE, 1'b0, rd);
    settle(2);
    check_word("torque offset", 32'h0, {24'h0, app_torque});
    op(1'b1, 12'h871, 32'h0, 1'b0, rd);
    settle(2);
    check_bit("all digital", 1'b0, spd_an | trq_an);
    op(1'b1, 12'h851, 32'h1, 1'b0, rd);
    op(1'b1, 12'h855, 32'h32, 1'b0, rd);
    @(posedge clk);
    load_pct <= 8'h32;
    settle(2);
    check_bit("overload on", 1'b1, ovl);
    @(posedge clk);
    load_pct <= 8'h31;
    settle(2);
    check_bit("overload off", 1'b0, ovl);
    $display("done route");
  endtask
  task automatic t_alarm;
    logic [31:0] rd;
    for (int b = 0; b < 2; b++) begin
      op(1'b1, 12'h840, b, 1'b0, rd);
      @(posedge clk);
      alarm_pin <= 1'b1;
      settle(3);
      check_bit("motor stop", 1'b1, mstop);
      check_bit("alarm out", 1'b0, prim);
      check_bit("brake", b[0], brake);
      if (b == 0) begin
        @(posedge clk);
        motor_stopped <= 1'b1;
        settle(2);
        check_bit("brake stopped", 1'b1, brake);
      end
      @(posedge clk);
      alarm_pin     <= 1'b0;
      motor_stopped <= 1'b0;
      settle(4);
      check_bit("alarm gone", 1'b1, prim);
    end
    op(1'b1, 12'h841, 32'h1, 1'b0, rd);
    @(posedge clk);
    initial_alarm <= 1'b1;
    settle(2);
    check_bit("run inhibit", 1'b1, inhibit);
    op(1'b1, 12'h841, 32'h0, 1'b0, rd);
    settle(1);
    check_bit("inhibit off", 1'b0, inhibit);
    $display("done alarm");
  endtask
  task automatic t_link;
    logic [31:0] rd;
    op(1'b1, 12'h901, 32'h2, 1'b0, rd);
    op(1'b0, 12'h8D4, 32'h0, 1'b1, rd);
    settle(1);
    check_bit("one error", 1'b0, lalarm);
    check_word("error count", 32'h1, {28'h0, err_count});
    op(1'b0, 12'h8D6, 32'h0, 1'b1, rd);
    settle(1);
    check_bit("error alarm", 1'b1, lalarm);
    check_word("count cleared", 32'h0, {28'h0, err_count});
    @(posedge clk);
    alarm_reset_pin <= 1'b1;
    settle(3);
    @(posedge clk);
    alarm_reset_pin <= 1'b0;
    settle(4);
    check_bit("alarm cleared", 1'b0, lalarm);
    op(1'b1, 12'h900, 32'h1, 1'b0, rd);
    settle(5);
    check_bit("timeout early", 1'b0, lalarm);
    settle(20);
    check_bit("timeout alarm", 1'b1, lalarm);
    $display("done link");
  endtask
  initial begin
    do_reset();
    t_reset_values();
    t_range();
    do_reset();
    t_apply();
    t_route();
    do_reset();
    t_alarm();
    t_link();
    test_done();
  end
endmodule
`default_nettype wire
